//--- tb/serial_partner.sv
// far-side model: mode 0 shift partner and asynchronous line
module serial_partner (
    input wire logic clk_pin_in,
    input wire logic dout_in,
    input wire logic oe_in,
    input wire logic lclk_in,
    input wire logic m0_in,
    input wire logic [7:0] byte_in,
    output logic din_out,
    output logic cap_v_out,
    output logic [8:0] cap_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] idx = 3'h0, cnt = 3'h0;
    logic [7:0] sh = 8'h00;
    logic [10:0] fr = 11'h000;
    logic ser = 1'b1;
    initial cap_v_out = 1'b0;
    assign din_out = m0_in ? byte_in[idx] : ser;
    task automatic pulse(input logic [8:0] v);
        cap_out = v;
        cap_v_out = 1'b1;
        #1 cap_v_out = 1'b0;
    endtask : pulse
    // next bit goes out right after the sampling edge, so it is settled a whole period early
    always @(posedge clk_pin_in) begin
        if (m0_in && oe_in) begin
            sh = {dout_in, sh[7:1]};
            cnt = cnt + 3'h1;
            if (cnt == 3'h0) pulse({1'b0, sh});
        end else if (m0_in) begin
            idx = idx + 3'h1;
        end
    end
    always @(negedge clk_pin_in) begin
        if (!m0_in) begin
            repeat (8) @(posedge lclk_in);
            for (int i = 0; i < 11; i++) begin
                fr[i] = clk_pin_in;
                repeat (16) @(posedge lclk_in);
            end
            pulse({fr[9], fr[8:1]});
        end
    end
    // the line moves on the falling link edge, away from the edge the port samples on
    task automatic send(input logic [10:0] bits, input int n);
        @(negedge lclk_in);
        for (int i = 0; i < n; i++) begin
            ser = bits[i];
            repeat (16) @(negedge lclk_in);
        end
        ser = 1'b1;
    endtask : send
endmodule : serial_partner

//--- tb/uart_ctrl_status_mode0_chk.sv
// concurrent checks on the serial port's register bus and mode 0 pins
module uart_ctrl_status_mode0_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic link_clk_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic data_pin_in,
    input wire logic data_pin_out,
    input wire logic data_pin_oe_out,
    input wire logic clk_pin_out
);
    logic [7:0] ctrl_q;
    logic [7:0] oe_cnt_q;
    // hardware never touches bits 7:3, so a shadow of the writes is exact there
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= 8'h00;
            oe_cnt_q <= 8'h00;
        end else begin
            if (sfr_wr_in && sfr_addr_in == 8'hc0) begin
                ctrl_q <= sfr_wdata_in;
            end
            oe_cnt_q <= data_pin_oe_out ? oe_cnt_q + 8'h01 : 8'h00;
        end
    end
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_unmapped_zero:
        assert property (sfr_rd_in && sfr_addr_in != 8'hc0 && sfr_addr_in != 8'hc1 |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_holds:
        assert property (!sfr_rd_in |=> $stable(sfr_rdata_out)) else $error("read data moved without a read");
    chk_ctrl_readback:
        assert property (sfr_rd_in && !sfr_wr_in && sfr_addr_in == 8'hc0 |=> sfr_rdata_out[7:3] == ctrl_q[7:3])
        else $error("control bits read back wrong");
    chk_shift_start:
        assert property ($rose(data_pin_oe_out) |-> !clk_pin_out && $past(sfr_wr_in) && $past(sfr_addr_in) == 8'hc1)
        else $error("shift out began without a buffer write");
    chk_shift_span:
        assert property ($fell(data_pin_oe_out) |-> oe_cnt_q == 8'h20 || oe_cnt_q == 8'h60)
        else $error("shift out length is not eight bit times");
    chk_data_on_fall:
        assert property (data_pin_oe_out && $past(data_pin_oe_out) && $changed(data_pin_out) |-> $fell(clk_pin_out))
        else $error("data changed away from a clock fall");
    chk_clk_low_half:
        assert property (data_pin_oe_out && $fell(clk_pin_out) |-> !clk_pin_out [*2]) else $error("low phase short");
    chk_clk_high_half:
        assert property (data_pin_oe_out && $rose(clk_pin_out) |-> clk_pin_out [*2]) else $error("high phase short");
endmodule : uart_ctrl_status_mode0_chk

//--- tb/uart_ctrl_status_mode0_test.sv
// self-checking bench for the serial port control block
module uart_ctrl_status_mode0_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, link_clk_in = 1'b0, rst_n_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out, rx_byte = 8'h00;
    logic data_pin_in, data_pin_out, data_pin_oe_out, clk_pin_out, far_pin, cap_v, m0 = 1'b0, rd_seen = 1'b0;
    logic [8:0] cap;
    logic [15:0] q_rd[$];
    logic [8:0] q_cap[$];
    logic [7:0] ctl[3] = '{8'h70, 8'h50, 8'hf0};
    int bad_count = 0, n_checks = 0, oe_cnt = 0;
    always #50 clk_in = ~clk_in;
    always #6 link_clk_in = ~link_clk_in;
    // the data pin is shared: the port owns it only while its enable is up
    assign data_pin_in = data_pin_oe_out ? data_pin_out : far_pin;
    uart_ctrl_status_mode0 dut_u (.clk_in, .rst_n_in, .link_clk_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
        .sfr_wdata_in, .sfr_rdata_out, .data_pin_in, .data_pin_out, .data_pin_oe_out, .clk_pin_out);
    serial_partner pm_u (.clk_pin_in(clk_pin_out), .dout_in(data_pin_out), .oe_in(data_pin_oe_out),
        .lclk_in(link_clk_in), .m0_in(m0), .byte_in(rx_byte), .din_out(far_pin), .cap_v_out(cap_v), .cap_out(cap));
    task automatic cmp_reg(input logic [7:0] got, input logic [15:0] e);
        n_checks++;
        if ((got & e[15:8]) !== e[7:0]) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, e[7:0]);
        end
    endtask : cmp_reg
    task automatic cmp_val(input logic [8:0] got, input logic [8:0] e);
        n_checks++;
        if (got !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, e);
        end
    endtask : cmp_val
    always @(posedge clk_in) rd_seen <= sfr_rd_in;
    always @(negedge clk_in) if (rd_seen) cmp_reg(sfr_rdata_out, q_rd.pop_front());
    always @(negedge clk_in) if (data_pin_oe_out) oe_cnt++;
    always @(posedge cap_v) cmp_val(cap, q_cap.pop_front());
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(negedge clk_in);
        sfr_wr_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge clk_in);
        sfr_addr_in = a;
        sfr_rd_in = 1'b1;
        q_rd.push_back({m, e & m});
        @(negedge clk_in);
        sfr_rd_in = 1'b0;
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(negedge clk_in);
    endtask : idle
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin : main
        logic [7:0] b;
        int n;
        void'($urandom(32'h6aad1c6a));
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        rd(8'hc0, 8'h00, 8'hff);
        rd(8'($urandom_range(191)), 8'h00, 8'hff);
        for (int m = 0; m < 4; m++) begin
            wr(8'hc0, {2'(m), 6'h28});
            rd(8'hc0, {2'(m), 6'h28}, 8'hf8);
        end
        m0 = 1'b1;
        for (int s = 0; s < 2; s++) begin
            n = s ? 12 : 4;
            b = 8'($urandom);
            wr(8'hc0, s ? 8'h00 : 8'h20);
            oe_cnt = 0;
            q_cap.push_back({1'b0, b});
            wr(8'hc1, b);
            wr(8'hc1, ~b);
            idle(8 * n + 4);
            cmp_val(9'(oe_cnt), 9'(8 * n));
            rd(8'hc0, 8'h02, 8'h03);
            idle(50);
            rd(8'hc0, 8'h02, 8'h02);
        end
        rx_byte = 8'($urandom);
        wr(8'hc0, 8'h00);
        idle(120);
        rd(8'hc0, 8'h00, 8'h03);
        wr(8'hc0, 8'h10);
        idle(110);
        rd(8'hc0, 8'h01, 8'h03);
        rd(8'hc1, rx_byte, 8'hff);
        m0 = 1'b0;
        for (int k = 0; k < 3; k++) begin
            b = 8'($urandom);
            wr(8'hc0, ctl[k]);
            pm_u.send({1'b1, k == 2, b, 1'b0}, k == 2 ? 11 : 10);
            idle(10);
            rd(8'hc0, k == 0 ? 8'h00 : {5'h00, k == 2, 2'b01}, 8'h05);
            if (k != 0) rd(8'hc1, b, 8'hff);
        end
        // last pass runs mode 1: its stop bit lands where the ninth bit would
        for (int t = 0; t < 3; t++) begin
            b = 8'($urandom);
            wr(8'hc0, t == 2 ? 8'h40 : {4'h8, t[0], 3'h0});
            q_cap.push_back({t != 0, b});
            wr(8'hc1, b);
            idle(40);
            rd(8'hc0, 8'h02, 8'h02);
        end
        // let the watcher take the last read before the verdict
        idle(2);
        report_and_stop();
    end
    // the sequence needs under eight hundred cycles; twenty thousand means a hang
    initial begin
        #2000000;
        bad_count++;
        report_and_stop();
    end
endmodule : uart_ctrl_status_mode0_test
bind uart_ctrl_status_mode0 uart_ctrl_status_mode0_chk chk_u (.clk_in, .rst_n_in, .link_clk_in, .sfr_addr_in,
    .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .data_pin_in, .data_pin_out, .data_pin_oe_out,
    .clk_pin_out);

//--- verilog/uart_ctrl_status_mode0.sv
// serial port: control/status register, mode 0 shifter, async framer
// ********************************
// overview
// ********************************

// Overview of operation
// - top two control bits select mode 0..3
// - mode 0 shift clock: clk/4 or clk/12
// - mode 1, multiproc on: stop must be high
// - mode 1, multiproc off: stop bit ignored
// - modes 2/3 send software ninth bit
// - mode 0 tx flag after eighth bit
// - modes 1-3 tx flag at stop start
// - mode 0 rx flag after eighth bit
// - mode 1 rx flag after stop sample
// - modes 2/3 rx flag at stop sample
// - done flags cleared only by software
// - mode 0 is 8-bit shifter, clock out
// - control register at address c0, read/write
// - reception needs receive enable set
// - mode 1 stores stop bit as ninth
// - modes 2/3 store ninth bit, ignore stop
// - mode 0 shifts lsb first
module uart_ctrl_status_mode0 (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic link_clk_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe_out,
    output logic clk_pin_out
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [7:0] scon;
        logic [7:0] sbuf_rx;
        logic [7:0] rdata;
        logic [8:0] tx_word;
        logic tx_busy;
        logic go_tgl;
        uart_pkg::m0_state_t m0;
        logic [3:0] phase;
        logic [2:0] bitn;
        logic [7:0] shreg;
        logic sclk;
        logic dout;
        logic doe;
        logic din_s1;
        logic din_s2;
        logic ti_s1;
        logic ti_s2;
        logic ti_s3;
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
    } sys_t;

    typedef struct packed {
        logic [1:0] mode_s1;
        logic [1:0] mode_s2;
        logic ren_s1;
        logic ren_s2;
        logic go_s1;
        logic go_s2;
        logic go_ack;
        logic rxd_s1;
        logic rxd_s2;
        logic rxd_s3;
        logic tx_act;
        logic [3:0] tx_tick;
        logic [3:0] tx_idx;
        logic [9:0] tx_sh;
        logic txd;
        logic ti_tgl;
        logic rx_act;
        logic [3:0] rx_tick;
        logic [3:0] rx_idx;
        logic [7:0] rx_sh;
        logic rx_nine_tmp;
        logic [7:0] rx_word;
        logic rx_nine;
        logic rx_tgl;
    } lnk_t;

    sys_t s_q;
    sys_t s_d;
    lnk_t l_q;
    lnk_t l_d;

    function automatic uart_pkg::mode_t mode_of(input logic [1:0] bits);
        return uart_pkg::mode_t'(bits);
    endfunction : mode_of

    function automatic logic [3:0] last_idx(input uart_pkg::mode_t m);
        return (m == uart_pkg::MODE1) ? uart_pkg::FRAME10_LAST : uart_pkg::FRAME11_LAST;
    endfunction : last_idx

    // ********************************
    // cpu clock domain
    // ********************************
    logic wr_scon;
    logic wr_sbuf;
    uart_pkg::mode_t s_mode;
    logic [3:0] div;

    always_comb begin
        s_d = s_q;
        wr_scon = sfr_wr_in && (sfr_addr_in == uart_pkg::SCON_ADDR);
        wr_sbuf = sfr_wr_in && (sfr_addr_in == uart_pkg::SBUF_ADDR);
        s_mode = mode_of(s_q.scon[uart_pkg::MODE_HI:uart_pkg::MODE_LO]);
        div = s_q.scon[uart_pkg::MP_EN] ? uart_pkg::DIV_FAST : uart_pkg::DIV_SLOW;
        s_d.din_s1 = data_pin_in;
        s_d.din_s2 = s_q.din_s1;
        s_d.ti_s1 = l_q.ti_tgl;
        s_d.ti_s2 = s_q.ti_s1;
        s_d.ti_s3 = s_q.ti_s2;
        s_d.rx_s1 = l_q.rx_tgl;
        s_d.rx_s2 = s_q.rx_s1;
        s_d.rx_s3 = s_q.rx_s2;
        // software write lands first so that a hardware set below wins
        if (wr_scon) begin
            s_d.scon = sfr_wdata_in;
        end
        if (sfr_rd_in) begin
            if (sfr_addr_in == uart_pkg::SCON_ADDR) begin
                s_d.rdata = s_q.scon;
            end else if (sfr_addr_in == uart_pkg::SBUF_ADDR) begin
                s_d.rdata = s_q.sbuf_rx;
            end else begin
                s_d.rdata = uart_pkg::UNMAPPED_READ;
            end
        end
        // async transmit: word and ninth bit held until the link reports stop
        if (wr_sbuf && s_mode != uart_pkg::MODE0 && !s_q.tx_busy) begin
            s_d.tx_word = {s_q.scon[uart_pkg::TB8], sfr_wdata_in};
            s_d.tx_busy = 1'b1;
            s_d.go_tgl = ~s_q.go_tgl;
        end
        if (s_q.ti_s2 != s_q.ti_s3) begin
            s_d.scon[uart_pkg::TI] = 1'b1;
            s_d.tx_busy = 1'b0;
        end
        // async receive: accept only if previous byte was collected
        if (s_q.rx_s2 != s_q.rx_s3 && !s_q.scon[uart_pkg::RI]
                && (!s_q.scon[uart_pkg::MP_EN] || l_q.rx_nine)) begin
            s_d.sbuf_rx = l_q.rx_word;
            s_d.scon[uart_pkg::RB8] = l_q.rx_nine;
            s_d.scon[uart_pkg::RI] = 1'b1;
        end
        // mode 0 shifter
        unique case (s_q.m0)
            uart_pkg::M0_IDLE: begin
                s_d.sclk = 1'b1;
                s_d.phase = 4'h0;
                s_d.bitn = 3'h0;
                if (s_mode == uart_pkg::MODE0 && wr_sbuf) begin
                    s_d.m0 = uart_pkg::M0_TX;
                    s_d.shreg = sfr_wdata_in;
                    s_d.dout = sfr_wdata_in[0];
                    s_d.doe = 1'b1;
                    s_d.sclk = 1'b0;
                end else if (s_mode == uart_pkg::MODE0 && s_q.scon[uart_pkg::REN]
                        && !s_q.scon[uart_pkg::RI] && !wr_scon) begin
                    s_d.m0 = uart_pkg::M0_RX;
                    s_d.doe = 1'b0;
                    s_d.sclk = 1'b0;
                end
            end
            uart_pkg::M0_TX,
            uart_pkg::M0_RX: begin
                s_d.phase = s_q.phase + 4'h1;
                // low for the first half of a bit, high for the second
                if (s_q.phase + 4'h1 == (div >> 1)) begin
                    s_d.sclk = 1'b1;
                    if (s_q.m0 == uart_pkg::M0_RX) begin
                        s_d.shreg = {s_q.din_s2, s_q.shreg[7:1]};
                    end
                end
                if (s_q.phase + 4'h1 >= div) begin
                    s_d.phase = 4'h0;
                    if (s_q.bitn == uart_pkg::M0_LAST_BIT) begin
                        s_d.m0 = uart_pkg::M0_IDLE;
                        s_d.doe = 1'b0;
                        s_d.sclk = 1'b1;
                        if (s_q.m0 == uart_pkg::M0_TX) begin
                            s_d.scon[uart_pkg::TI] = 1'b1;
                        end else begin
                            s_d.sbuf_rx = s_q.shreg;
                            s_d.scon[uart_pkg::RI] = 1'b1;
                        end
                    end else begin
                        s_d.bitn = s_q.bitn + 3'h1;
                        s_d.sclk = 1'b0;
                        if (s_q.m0 == uart_pkg::M0_TX) begin
                            s_d.shreg = {1'b0, s_q.shreg[7:1]};
                            s_d.dout = s_q.shreg[1];
                        end
                    end
                end
            end
            default: begin
                s_d.m0 = uart_pkg::M0_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.scon <= uart_pkg::SCON_RESET;
            s_q.sbuf_rx <= uart_pkg::SBUF_RESET;
            s_q.sclk <= 1'b1;
            s_q.m0 <= uart_pkg::M0_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************
    // link clock domain (16 ticks per bit)
    // ********************************
    uart_pkg::mode_t l_mode;

    always_comb begin
        l_d = l_q;
        l_mode = mode_of(l_q.mode_s2);
        l_d.mode_s1 = s_q.scon[uart_pkg::MODE_HI:uart_pkg::MODE_LO];
        l_d.mode_s2 = l_q.mode_s1;
        l_d.ren_s1 = s_q.scon[uart_pkg::REN];
        l_d.ren_s2 = l_q.ren_s1;
        l_d.go_s1 = s_q.go_tgl;
        l_d.go_s2 = l_q.go_s1;
        l_d.rxd_s1 = data_pin_in;
        l_d.rxd_s2 = l_q.rxd_s1;
        l_d.rxd_s3 = l_q.rxd_s2;
        // transmitter: go_ack keeps a request that arrives mid-frame
        if (!l_q.tx_act) begin
            l_d.txd = 1'b1;
            if (l_q.go_s2 != l_q.go_ack && l_mode != uart_pkg::MODE0) begin
                l_d.go_ack = l_q.go_s2;
                l_d.tx_act = 1'b1;
                l_d.tx_tick = 4'h0;
                l_d.tx_idx = 4'h0;
                l_d.tx_sh = {1'b1, (l_mode == uart_pkg::MODE1) ? 1'b1 : s_q.tx_word[8],
                             s_q.tx_word[7:0]};
                l_d.txd = 1'b0;
            end
        end else begin
            l_d.tx_tick = l_q.tx_tick + 4'h1;
            if (l_q.tx_tick == uart_pkg::TICK_LAST) begin
                if (l_q.tx_idx == last_idx(l_mode)) begin
                    l_d.tx_act = 1'b0;
                    l_d.txd = 1'b1;
                end else begin
                    l_d.tx_idx = l_q.tx_idx + 4'h1;
                    l_d.txd = l_q.tx_sh[0];
                    l_d.tx_sh = {1'b1, l_q.tx_sh[9:1]};
                    if (l_q.tx_idx + 4'h1 == last_idx(l_mode)) begin
                        l_d.ti_tgl = ~l_q.ti_tgl;
                    end
                end
            end
        end
        // receiver: start on falling edge, sample mid-bit
        if (!l_q.rx_act) begin
            if (l_q.ren_s2 && l_mode != uart_pkg::MODE0
                    && l_q.rxd_s3 && !l_q.rxd_s2) begin
                l_d.rx_act = 1'b1;
                l_d.rx_tick = 4'h0;
                l_d.rx_idx = 4'h0;
            end
        end else begin
            l_d.rx_tick = l_q.rx_tick + 4'h1;
            if (l_q.rx_tick == uart_pkg::TICK_LAST) begin
                l_d.rx_idx = l_q.rx_idx + 4'h1;
            end
            if (l_q.rx_tick == uart_pkg::TICK_SAMPLE) begin
                if (l_q.rx_idx == 4'h0) begin
                    l_d.rx_act = !l_q.rxd_s2;
                end else if (l_q.rx_idx == last_idx(l_mode)) begin
                    l_d.rx_act = 1'b0;
                    l_d.rx_word = l_q.rx_sh;
                    // mode 1 keeps the stop bit, modes 2/3 the ninth bit
                    l_d.rx_nine = (l_mode == uart_pkg::MODE1) ? l_q.rxd_s2 : l_q.rx_nine_tmp;
                    l_d.rx_tgl = ~l_q.rx_tgl;
                end else if (l_q.rx_idx == uart_pkg::NINTH_IDX) begin
                    l_d.rx_nine_tmp = l_q.rxd_s2;
                end else begin
                    l_d.rx_sh = {l_q.rxd_s2, l_q.rx_sh[7:1]};
                end
            end
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            l_q <= '0;
            l_q.txd <= 1'b1;
            l_q.rxd_s1 <= 1'b1;
            l_q.rxd_s2 <= 1'b1;
            l_q.rxd_s3 <= 1'b1;
        end else begin
            l_q <= l_d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign sfr_rdata_out = s_q.rdata;
    assign data_pin_out = s_q.dout;
    assign data_pin_oe_out = s_q.doe;
    // mode is static while a frame runs, so the domain mux does not glitch mid-bit
    assign clk_pin_out = (s_mode == uart_pkg::MODE0) ? s_q.sclk : l_q.txd;

endmodule : uart_ctrl_status_mode0

//--- verilog/uart_pkg.sv
// constants and types for the serial port control block
package uart_pkg;

    // ********************************
    // register map
    // ********************************
    localparam logic [7:0] SCON_ADDR = 8'hc0;
    localparam logic [7:0] SBUF_ADDR = 8'hc1;
    localparam logic [7:0] SCON_RESET = 8'h00;
    localparam logic [7:0] SBUF_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ********************************
    // field positions of serial_mode_flags
    // ********************************
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int MP_EN = 5;
    localparam int REN = 4;
    localparam int TB8 = 3;
    localparam int RB8 = 2;
    localparam int TI = 1;
    localparam int RI = 0;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_HZ = 10000000;
    localparam int RATIO_FAST = 4;
    localparam int RATIO_SLOW = 12;
    localparam logic [3:0] DIV_FAST = 4'(RATIO_FAST);
    localparam logic [3:0] DIV_SLOW = 4'(RATIO_SLOW);
    localparam logic [2:0] M0_LAST_BIT = 3'h7;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_SAMPLE = 4'h7;
    localparam logic [3:0] FRAME10_LAST = 4'h9;
    localparam logic [3:0] FRAME11_LAST = 4'ha;
    localparam logic [3:0] NINTH_IDX = 4'h9;

    typedef enum logic [1:0] {MODE0, MODE1, MODE2, MODE3} mode_t;
    typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX} m0_state_t;

endpackage : uart_pkg
